// >>> dv/reset_source_combiner_test.sv
`timescale 1ns/1ps
`default_nettype none
module reset_source_combiner_test;
   import rst_comb_pkg::*;
   logic clk_i = 0, rst_i = 1, pin_n = 1, wdt = 0, bor = 0, config_mismatch_flag = 0;
   logic slp = 0, idl = 0, unl = 0, wr = 0, rd = 0, rd_d = 0;
   logic master_system_reset, vreg;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, exp, lfsr = 32'head2;
   logic [31:0] q[$];
   // expected flags per source: pin, wdt in sleep, bor, cmr in idle
   logic [31:0] flag_tab [4] = '{32'h80, 32'h18, 32'h2, 32'h204};
   int fail_count = 0, checks = 0, n;
   always #5 clk_i = ~clk_i;
   reset_source_combiner i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .master_clear_pin_n_i(pin_n), .watchdog_reset_source_i(wdt),
      .brownout_i(bor), .cfg_mismatch_i(config_mismatch_flag), .in_sleep_i(slp),
      .in_idle_i(idl), .unlocked_i(unl), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .master_system_reset_o(master_system_reset), .regulator_standby_enable_o(vreg));
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      checks++;
      if (got !== want) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // for a read, d is the value expected back
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (!w) q.push_back(d);
      @(posedge clk_i);
      wr <= 0;
      rd <= 0;
      @(posedge clk_i);
   endtask
   task automatic quiet;
      repeat (8) @(negedge clk_i);
      check({31'h0, master_system_reset}, 32'h0);
      @(posedge clk_i);
   endtask
   task automatic hold_len;
      n = 0;
      while (master_system_reset !== 1'b1 && n < 30) begin
         @(negedge clk_i);
         n++;
      end
      check({31'h0, master_system_reset}, 32'h1);
      n = 0;
      while (master_system_reset === 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      check({31'h0, n >= 10 && n < 40}, 32'h1);
      @(posedge clk_i);
   endtask
   // read data stands only in the cycle after the read strobe
   always @(posedge clk_i) rd_d <= rd;
   always @(negedge clk_i)
      if (rd_d) check(rdata, q.pop_front());
   initial begin
      repeat (3000) @(posedge clk_i);
      fail_count++;
      close_out;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      repeat (2) @(posedge clk_i);
      bus(0, 8'h00, 32'h3);
      bus(0, 8'h04, 32'h0);
      bus(0, 8'h10, 32'h0);
      lfsr = next_rand(lfsr);
      bus(1, 8'h00, lfsr);
      bus(0, 8'h00, lfsr & 32'h3df);
      check({31'h0, vreg}, {31'h0, lfsr[8]});
      bus(1, 8'h00, 32'h100);
      check({31'h0, vreg}, 32'h1);
      bus(1, 8'h00, 32'h0);
      check({31'h0, vreg}, 32'h0);
      bus(0, 8'h00, 32'h0);
      $display("test registers done");
      bus(1, 8'h04, 32'h1);
      quiet;
      unl <= 1;
      bus(1, 8'h04, 32'h0);
      quiet;
      bus(1, 8'h04, 32'h1);
      hold_len;
      exp = 32'h40;
      bus(0, 8'h00, exp);
      bus(0, 8'h04, 32'h0);
      $display("test soft reset done");
      // flags pile up: earlier causes survive later system resets
      for (int s = 0; s < 4; s++) begin
         slp <= (s == 1);
         idl <= (s == 3);
         case (s)
            0: pin_n <= 0;
            1: wdt <= 1;
            2: bor <= 1;
            default: config_mismatch_flag <= 1;
         endcase
         repeat (2) @(posedge clk_i);
         pin_n <= 1;
         wdt <= 0;
         bor <= 0;
         config_mismatch_flag <= 0;
         hold_len;
         slp <= 0;
         idl <= 0;
         exp = exp | flag_tab[s];
         bus(0, 8'h00, exp);
      end
      $display("test sources done");
      close_out;
   end
endmodule
`default_nettype wire

// >>> hw/reset_source_combiner.sv
`timescale 1ns/1ps
`default_nettype none
`include "rst_comb_map.svh"
module reset_source_combiner
   import rst_comb_pkg::*;
(
   // clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_i,
   // reset sources from pins and detectors, plus sleep and idle state
   input wire logic master_clear_pin_n_i,
   input wire logic watchdog_reset_source_i,
   input wire logic brownout_i,
   input wire logic cfg_mismatch_i,
   input wire logic in_sleep_i,
   input wire logic in_idle_i,
   // unlock state from the system unlock unit
   input wire logic unlocked_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // results
   output logic master_system_reset_o,
   output logic regulator_standby_enable_o
);
   localparam logic [3:0] HOLD_CYC = 4'(`RST_HOLD_CYC);
   localparam logic [31:0] CAUSE_MASK_W = `CAUSE_MASK;

   state_t st_ff;
   state_t nxt_st;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   logic [31:0] cause_word;
   // regulator enable lives apart from the flags but reads back in bit 8
   always_comb begin
      cause_word = {22'h0, st_ff.cause} & CAUSE_MASK_W;
      cause_word[`VREG_BIT] = st_ff.vreg;
   end

   always_comb begin
      logic any_src;
      logic sw_fire;
      any_src = 1'b0;
      sw_fire = 1'b0;
      nxt_st = st_ff;
      nxt_st.sync1.pin = ~master_clear_pin_n_i;
      nxt_st.sync1.wdt = watchdog_reset_source_i;
      nxt_st.sync1.bor = brownout_i;
      nxt_st.sync1.config_mismatch_flag = cfg_mismatch_i;
      nxt_st.sync1.sleep = in_sleep_i;
      nxt_st.sync1.idle = in_idle_i;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.unlocked = unlocked_i;
      nxt_st.sw_req = 1'b0;
      nxt_st.rdata = 32'h0;
      if (rd_i) begin
         if (hit(addr_i, `CAUSE_REG_OFS)) begin
            nxt_st.rdata = cause_word;
         end
         // trigger register reads zero
      end
      // software writes first; hardware sets below win
      if (wr_i && hit(addr_i, `CAUSE_REG_OFS)) begin
         nxt_st.cause = wdata_i[9:0] & CAUSE_MASK_W[9:0];
      end
      if (wr_i && hit(addr_i, `TRIG_REG_OFS) && wdata_i[`TRIG_BIT]
          && st_ff.unlocked) begin
         nxt_st.sw_req = 1'b1;
      end
      sw_fire = st_ff.sw_req;
      if (st_ff.sync2.config_mismatch_flag) nxt_st.cause[`CMR_BIT] = 1'b1;
      if (st_ff.sync2.pin) nxt_st.cause[`PIN_BIT] = 1'b1;
      if (sw_fire) nxt_st.cause[`SWR_BIT] = 1'b1;
      if (st_ff.sync2.wdt) nxt_st.cause[`WDT_BIT] = 1'b1;
      if (st_ff.sync2.bor) nxt_st.cause[`BOR_BIT] = 1'b1;
      // sleep/idle captured when a reset starts from that state
      any_src = st_ff.sync2.pin | st_ff.sync2.wdt | st_ff.sync2.bor
         | st_ff.sync2.config_mismatch_flag | sw_fire;
      if (any_src && st_ff.sync2.sleep) begin
         nxt_st.cause[`SLEEP_BIT] = 1'b1;
      end
      if (any_src && st_ff.sync2.idle) begin
         nxt_st.cause[`IDLE_BIT] = 1'b1;
      end
      if (wr_i && hit(addr_i, `CAUSE_REG_OFS)) begin
         nxt_st.vreg = wdata_i[`VREG_BIT];
      end
      nxt_st.cause[`VREG_BIT] = 1'b0;
      // cause register never cleared by the system reset itself
      case (st_ff.seq)
         st_run: begin
            nxt_st.master_system_reset = 1'b0;
            if (any_src) begin
               nxt_st.seq = st_hold;
               nxt_st.cnt = HOLD_CYC;
               nxt_st.master_system_reset = 1'b1;
            end
         end
         st_hold: begin
            nxt_st.master_system_reset = 1'b1;
            if (any_src) begin
               nxt_st.cnt = HOLD_CYC;
            end else if (st_ff.cnt == 4'h1) begin
               nxt_st.seq = st_run;
               nxt_st.master_system_reset = 1'b0;
            end else begin
               nxt_st.cnt = st_ff.cnt - 4'h1;
            end
         end
         default: begin
            nxt_st.seq = st_run;
            nxt_st.master_system_reset = 1'b1;
         end
      endcase
   end

   // power-on reset: rst_i held high, other flags zero, bits 1 and 0 set
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.cause <= `CAUSE_POR_VAL;
         st_ff.seq <= st_run;
         st_ff.master_system_reset <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata_o = st_ff.rdata;
   assign master_system_reset_o = st_ff.master_system_reset;
   assign regulator_standby_enable_o = st_ff.vreg;

   chk_por_flags_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i)
      |-> (st_ff.cause == `CAUSE_POR_VAL) && master_system_reset_o)
      else $error("power-on flags not set after power-on reset");
   chk_reserved_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rdata_o[31:10] == 22'h0) && !rdata_o[5])
      else $error("reserved cause bits nonzero");
   chk_trig_locked: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_i && hit(addr_i, `TRIG_REG_OFS) && !st_ff.unlocked) |=> !st_ff.sw_req)
      else $error("trigger accepted while locked");
   chk_trig_fire: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_i && hit(addr_i, `TRIG_REG_OFS) && wdata_i[0] && st_ff.unlocked)
      |=> st_ff.sw_req ##1 (!st_ff.sw_req && master_system_reset_o))
      else $error("software reset not raised");
   chk_swr_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_ff.sw_req |=> st_ff.cause[`SWR_BIT])
      else $error("software flag not set");
   chk_pin_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_ff.sync2.pin |=> (st_ff.cause[`PIN_BIT] && master_system_reset_o))
      else $error("pin reset not recorded");
   chk_wdt_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_ff.sync2.wdt |=> st_ff.cause[`WDT_BIT])
      else $error("watchdog flag not set");
   chk_cmr_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_ff.sync2.config_mismatch_flag |=> st_ff.cause[`CMR_BIT])
      else $error("mismatch flag not set");
   chk_bor_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_ff.sync2.bor |=> st_ff.cause[`BOR_BIT])
      else $error("brown-out flag not set");
   // assertion helper: cycles the system reset has stood high;
   // power-on counts as long enough, the supply holds rst_i itself
   logic [3:0] hold_seen_ff;
   logic [3:0] nxt_hold_seen;
   always_comb begin
      nxt_hold_seen = hold_seen_ff;
      if (!master_system_reset_o) begin
         nxt_hold_seen = 4'h0;
      end else if (hold_seen_ff != 4'hf) begin
         nxt_hold_seen = hold_seen_ff + 4'h1;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hold_seen_ff <= 4'hf;
      end else begin
         hold_seen_ff <= nxt_hold_seen;
      end
   end

   chk_hold_len: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(master_system_reset_o) |-> (hold_seen_ff >= HOLD_CYC))
      else $error("system reset too short");
   chk_vreg_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_i && hit(addr_i, `CAUSE_REG_OFS))
      |=> regulator_standby_enable_o == $past(wdata_i[8]))
      else $error("regulator enable not written");
   chk_sleep_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (st_ff.sync2.sleep && (st_ff.sync2.pin || st_ff.sync2.wdt
         || st_ff.sync2.bor || st_ff.sync2.config_mismatch_flag || st_ff.sw_req))
      |=> st_ff.cause[`SLEEP_BIT])
      else $error("sleep flag not set");
   chk_idle_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (st_ff.sync2.idle && (st_ff.sync2.pin || st_ff.sync2.wdt
         || st_ff.sync2.bor || st_ff.sync2.config_mismatch_flag || st_ff.sw_req))
      |=> st_ff.cause[`IDLE_BIT])
      else $error("idle flag not set");
   chk_reset_merge: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (st_ff.sync2.pin || st_ff.sync2.wdt || st_ff.sync2.bor
         || st_ff.sync2.config_mismatch_flag || st_ff.sw_req)
      |=> master_system_reset_o)
      else $error("source did not raise system reset");
   chk_reset_quiet: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (st_ff.seq == st_run && !st_ff.sync2.pin && !st_ff.sync2.wdt
         && !st_ff.sync2.bor && !st_ff.sync2.config_mismatch_flag && !st_ff.sw_req)
      |=> !master_system_reset_o)
      else $error("system reset without a source");
   chk_trig_clear: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !wr_i |=> !st_ff.sw_req)
      else $error("trigger did not clear itself");
   chk_trig_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_i && hit(addr_i, `TRIG_REG_OFS) && !wdata_i[`TRIG_BIT])
      |=> !st_ff.sw_req)
      else $error("writing zero raised a software reset");
   chk_trig_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_i && hit(addr_i, `TRIG_REG_OFS)) |=> (rdata_o == 32'h0))
      else $error("trigger register read nonzero");
   chk_vreg_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_i && hit(addr_i, `CAUSE_REG_OFS))
      |=> rdata_o[`VREG_BIT] == $past(regulator_standby_enable_o))
      else $error("regulator enable not read back");
   chk_rdata_idle: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rd_i |=> (rdata_o == 32'h0))
      else $error("read data outside its cycle");
   chk_por_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_i && hit(addr_i, `CAUSE_REG_OFS))
      |=> st_ff.cause[`POR_BIT] == $past(wdata_i[`POR_BIT]))
      else $error("power-on flag not writable");
   chk_flags_kept: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !(wr_i && hit(addr_i, `CAUSE_REG_OFS))
      |=> (st_ff.cause & $past(st_ff.cause)) == $past(st_ff.cause))
      else $error("cause flag lost without a software write");
   chk_vreg_kept: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !(wr_i && hit(addr_i, `CAUSE_REG_OFS))
      |=> $stable(regulator_standby_enable_o))
      else $error("regulator enable changed without a write");
   chk_hold_count: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (st_ff.seq == st_hold && st_ff.cnt > 4'h1)
      |=> master_system_reset_o)
      else $error("system reset released early");
   chk_swr_only: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!st_ff.sw_req && !st_ff.cause[`SWR_BIT] && !wr_i)
      |=> !st_ff.cause[`SWR_BIT])
      else $error("software flag set without a software reset");
   chk_pin_sync: assert property (
      @(posedge clk_i) disable iff (rst_i)
      master_clear_pin_n_i ##1 master_clear_pin_n_i |=> !st_ff.sync2.pin)
      else $error("pin request without the pin");
   chk_pin_latency: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !master_clear_pin_n_i |-> ##3 st_ff.cause[`PIN_BIT])
      else $error("pin flag late");
   chk_wdt_latency: assert property (
      @(posedge clk_i) disable iff (rst_i)
      watchdog_reset_source_i |-> ##3 st_ff.cause[`WDT_BIT])
      else $error("watchdog flag late");
   chk_bor_latency: assert property (
      @(posedge clk_i) disable iff (rst_i)
      brownout_i |-> ##3 st_ff.cause[`BOR_BIT])
      else $error("brown-out flag late");
   chk_cmr_latency: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_mismatch_i |-> ##3 st_ff.cause[`CMR_BIT])
      else $error("mismatch flag late");
   chk_reset_latency: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!master_clear_pin_n_i || watchdog_reset_source_i || brownout_i
         || cfg_mismatch_i) |-> ##3 master_system_reset_o)
      else $error("system reset late");
endmodule
`default_nettype wire

// >>> shared/rst_comb_map.svh
`ifndef RST_COMB_MAP_SVH
`define RST_COMB_MAP_SVH
`define CAUSE_REG_OFS 8'h00
`define TRIG_REG_OFS 8'h04
`define CMR_BIT 9
`define VREG_BIT 8
`define PIN_BIT 7
`define SWR_BIT 6
`define WDT_BIT 4
`define SLEEP_BIT 3
`define IDLE_BIT 2
`define BOR_BIT 1
`define POR_BIT 0
`define TRIG_BIT 0
`define CAUSE_POR_VAL 10'h003
`define CAUSE_MASK 32'h0000_03df
`define RST_HOLD_NS 100
`define CLK_PERIOD_NS 10
`define RST_HOLD_CYC ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> shared/rst_comb_pkg.sv
package rst_comb_pkg;
   typedef enum logic [1:0] {st_run, st_hold} seq_t;
   typedef struct packed {
      logic pin;
      logic wdt;
      logic bor;
      logic config_mismatch_flag;
      logic sleep;
      logic idle;
   } src_t;
   typedef struct packed {
      src_t sync1;
      src_t sync2;
      logic [9:0] cause;
      logic unlocked;
      logic sw_req;
      seq_t seq;
      logic [3:0] cnt;
      logic master_system_reset;
      logic vreg;
      logic [31:0] rdata;
   } state_t;
endpackage
